// ===== hdl/button_ctrl_pkg.sv
// Constants and types for the push-button record and playback control block.
package button_ctrl_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_LAST = 16'hffff;
    localparam int CLK_NS = 50;
    localparam int PUD_NS = 25000;
    localparam int DB_NS = 10000000;
    localparam int PUD_CYC = (PUD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DB_CYC = (DB_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 20;
    localparam logic [1:0] SYNC_RESET = 2'h3;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_PWRUP = 5'h02,
        ST_RUN = 5'h04,
        ST_PAUSE = 5'h08,
        ST_OVF = 5'h10
    } state_e;
endpackage

// ===== hdl/button_ctrl.sv
// Push-button start, pause, resume and stop control with run indicator.
`timescale 1ns/1ns
module button_ctrl
    import button_ctrl_pkg::*;
#(
    parameter int PUD_COUNT = PUD_CYC,
    parameter int DB_COUNT = DB_CYC,
    parameter logic [15:0] END_ADDR = ADDR_LAST
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_start_pause_n,
    input wire logic i_stop_reset_in,
    input wire logic i_play_sel,
    input wire logic i_button_mode,
    input wire logic i_cue_mode,
    input wire logic i_marker_delete_mode,
    input wire logic i_loop_mode,
    input wire logic i_marker_found,
    input wire logic i_next_msg,
    output logic o_run_marker_out,
    output logic o_overflow_out_n,
    output logic o_powered,
    output logic o_record,
    output logic o_marker_write,
    output logic o_marker_erase,
    output logic [15:0] o_address
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers and edge detection.

logic [1:0] sp_sync;
logic [1:0] st_sync;
logic sp_prev;
logic [1:0] next_sp_sync;
logic [1:0] next_st_sync;

always_comb
begin
    next_sp_sync = {sp_sync[0], i_start_pause_n};
    next_st_sync = {st_sync[0], i_stop_reset_in};
end

always_ff @(posedge i_clk)
begin
    if (!i_resetn)
    begin
        sp_sync <= SYNC_RESET;
        st_sync <= 2'h0;
        sp_prev <= 1'b1;
    end
    else
    begin
        sp_sync <= next_sp_sync;
        st_sync <= next_st_sync;
        sp_prev <= sp_sync[1];
    end
end

logic sp_level;
logic stop_level;
logic sp_fall;
assign sp_level = sp_sync[1];
assign stop_level = st_sync[1];
assign sp_fall = sp_prev && !sp_level;

////////////////////////////////////////////////////////////////////////////////
// Debounce: start edges count only after the input has stayed high long enough.

logic [CNT_W-1:0] db_cnt;
logic [CNT_W-1:0] next_db_cnt;
logic db_ok;
logic press;

assign db_ok = (db_cnt == CNT_W'(DB_COUNT));
assign press = sp_fall && db_ok;

always_comb
begin
    if (!sp_level)
        next_db_cnt = '0;
    else if (!db_ok)
        next_db_cnt = db_cnt + CNT_W'(1);
    else
        next_db_cnt = db_cnt;
end

always_ff @(posedge i_clk)
begin
    if (!i_resetn)
        db_cnt <= CNT_W'(DB_COUNT);
    else
        db_cnt <= next_db_cnt;
end

////////////////////////////////////////////////////////////////////////////////
// Control state machine.

state_e state;
state_e next_state;
logic [15:0] addr;
logic [15:0] next_addr;
logic [CNT_W-1:0] pu_cnt;
logic [CNT_W-1:0] next_pu_cnt;
logic rec_mode;
logic next_rec_mode;
logic rec_paused;
logic next_rec_paused;
logic powered;
logic next_powered;
logic mark_wr;
logic next_mark_wr;
logic mark_er;
logic next_mark_er;
logic ovf_n;
logic next_ovf_n;
logic at_end;

assign at_end = (addr == END_ADDR);

always_comb
begin
    next_state = state;
    next_addr = addr;
    next_pu_cnt = pu_cnt;
    next_rec_mode = rec_mode;
    next_rec_paused = rec_paused;
    next_powered = powered;
    next_mark_wr = 1'b0;
    next_mark_er = 1'b0;
    next_ovf_n = ovf_n;
    if (stop_level || !i_button_mode)
    begin
        if (state == ST_RUN && rec_mode)
            next_mark_wr = 1'b1;
        next_state = ST_IDLE;
        next_addr = ADDR_ZERO;
        next_powered = 1'b0;
        next_ovf_n = 1'b1;
        next_rec_paused = 1'b0;
    end
    else
    begin
        case (state)
            ST_IDLE:
            begin
                if (sp_level && db_ok)
                    next_powered = 1'b0;
                if (press)
                begin
                    next_rec_mode = !i_play_sel;
                    next_rec_paused = 1'b0;
                    next_powered = 1'b1;
                    next_pu_cnt = CNT_W'(PUD_COUNT);
                    next_state = ST_PWRUP;
                end
            end
            ST_PWRUP:
            begin
                if (pu_cnt == '0)
                    next_state = ST_RUN;
                else
                    next_pu_cnt = pu_cnt - CNT_W'(1);
            end
            ST_RUN:
            begin
                if (press)
                begin
                    next_state = ST_PAUSE;
                    if (rec_mode)
                    begin
                        next_mark_wr = 1'b1;
                        next_rec_paused = 1'b1;
                    end
                end
                else if (!rec_mode && i_marker_found)
                    next_state = ST_PAUSE;
                else if (i_next_msg)
                begin
                    if (at_end && !rec_mode && i_loop_mode)
                        next_addr = ADDR_ZERO;
                    else if (at_end)
                    begin
                        next_state = ST_OVF;
                        next_ovf_n = 1'b0;
                    end
                    else
                        next_addr = addr + 16'h0001;
                end
            end
            ST_PAUSE:
            begin
                if (sp_level && db_ok)
                    next_powered = 1'b0;
                if (press)
                begin
                    next_rec_mode = !i_play_sel;
                    next_powered = 1'b1;
                    next_pu_cnt = CNT_W'(PUD_COUNT);
                    next_state = ST_PWRUP;
                    next_rec_paused = 1'b0;
                    if (rec_paused && i_play_sel)
                        next_addr = ADDR_ZERO;
                    else if (rec_paused && i_marker_delete_mode && !i_play_sel)
                        next_mark_er = 1'b1;
                    else if (rec_paused && !i_play_sel)
                        next_addr = addr + 16'h0001;
                    else if (i_play_sel && i_cue_mode)
                        next_addr = addr + 16'h0001;
                    // Playback pause to record keeps the address.
                end
            end
            ST_OVF:
            begin
                if (sp_level && db_ok)
                    next_powered = 1'b0;
                if (press)
                begin
                    next_addr = ADDR_ZERO;
                    next_rec_mode = 1'b0;
                    next_ovf_n = 1'b1;
                    next_powered = 1'b1;
                    next_pu_cnt = CNT_W'(PUD_COUNT);
                    next_state = ST_PWRUP;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end
end

always_ff @(posedge i_clk)
begin
    if (!i_resetn)
    begin
        state <= ST_IDLE;
        addr <= ADDR_ZERO;
        pu_cnt <= '0;
        rec_mode <= 1'b0;
        rec_paused <= 1'b0;
        powered <= 1'b0;
        mark_wr <= 1'b0;
        mark_er <= 1'b0;
        ovf_n <= 1'b1;
    end
    else
    begin
        state <= next_state;
        addr <= next_addr;
        pu_cnt <= next_pu_cnt;
        rec_mode <= next_rec_mode;
        rec_paused <= next_rec_paused;
        powered <= next_powered;
        mark_wr <= next_mark_wr;
        mark_er <= next_mark_er;
        ovf_n <= next_ovf_n;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Output registers.

logic run;
always_ff @(posedge i_clk)
begin
    if (!i_resetn)
        run <= 1'b0;
    else
        run <= (next_state == ST_RUN);
end

assign o_run_marker_out = run;
assign o_overflow_out_n = ovf_n;
assign o_powered = powered;
assign o_record = rec_mode;
assign o_marker_write = mark_wr;
assign o_marker_erase = mark_er;
assign o_address = addr;

////////////////////////////////////////////////////////////////////////////////
// Assertions.

logic live;
assign live = !stop_level && i_button_mode;

run_state_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (run == (state == ST_RUN)) && (!run || powered))
    else $error("run indicator differs from run state");

stop_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    stop_level |=> (addr == ADDR_ZERO && state == ST_IDLE && !powered))
    else $error("stop level did not clear and power down");

stop_marker_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (stop_level && state == ST_RUN && rec_mode) |=> mark_wr)
    else $error("stop during record left no marker");

pause_keep_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_RUN && press && !stop_level && i_button_mode)
    |=> (state == ST_PAUSE && addr == $past(addr)))
    else $error("pause changed the address");

rec_pause_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_RUN && rec_mode && press && !stop_level && i_button_mode) |=> mark_wr)
    else $error("record pause wrote no marker");

marker_pause_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_RUN && !rec_mode && i_marker_found && !stop_level && i_button_mode)
    |=> state == ST_PAUSE)
    else $error("marker did not pause playback");

debounce_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (sp_fall && !db_ok && live && state inside {ST_IDLE, ST_PAUSE, ST_OVF})
    |=> state == $past(state))
    else $error("start edge accepted inside debounce");

pwrup_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state != ST_PWRUP ##1 state == ST_PWRUP) |-> !run [*2])
    else $error("run rose without power-up delay");

ovf_restart_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_OVF && press && !stop_level && i_button_mode)
    |=> (addr == ADDR_ZERO && ovf_n))
    else $error("overflow restart did not reset address");

overflow_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_RUN && i_next_msg && at_end && !(i_loop_mode && !rec_mode) && live
    && !press && !(i_marker_found && !rec_mode)) |=> (state == ST_OVF && !ovf_n))
    else $error("end of memory did not raise overflow");

resume_keep_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_PAUSE && press && live && !rec_paused && !(i_play_sel && i_cue_mode))
    |=> (state == ST_PWRUP && addr == $past(addr)))
    else $error("resume moved the address");

rec_to_play_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_PAUSE && press && live && rec_paused && i_play_sel)
    |=> (addr == ADDR_ZERO && !rec_mode))
    else $error("playback after record pause did not start at zero");

rec_resume_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_PAUSE && press && live && rec_paused && !i_play_sel && !i_marker_delete_mode)
    |=> (addr == $past(addr) + 16'h0001 && rec_mode))
    else $error("record resume did not step past the marker");

marker_erase_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_PAUSE && press && live && rec_paused && !i_play_sel && i_marker_delete_mode)
    |=> (mark_er && addr == $past(addr)))
    else $error("marker delete resume did not erase in place");

cue_skip_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_PAUSE && press && live && !rec_paused && i_play_sel && i_cue_mode)
    |=> addr == $past(addr) + 16'h0001)
    else $error("cue resume did not skip to the next message");

loop_wrap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_RUN && !rec_mode && i_loop_mode && i_next_msg && at_end && live
    && !press && !i_marker_found) |=> (addr == ADDR_ZERO && ovf_n && state == ST_RUN))
    else $error("loop mode did not wrap to the start");

power_down_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ST_PAUSE && sp_level && db_ok && live) |=> !powered)
    else $error("paused block stayed powered after debounce");

record_start_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state == ST_RUN && rec_mode);
pause_resume_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state == ST_PAUSE ##[1:1000] state == ST_PWRUP);
overflow_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state == ST_OVF);
loop_wrap_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state == ST_RUN && i_loop_mode && at_end && i_next_msg);
marker_erase_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
    mark_er);

endmodule

// ===== verification/button_pad.sv
// Model of the start/pause push button and the stop switch.
`timescale 1ns/1ns
module button_pad
(
    input wire logic i_clk,
    input wire logic i_press,
    input wire logic i_stop,
    output logic o_start_pause_n,
    output logic o_stop_reset_in,
    output logic o_button_mode
);
    logic [1:0] low_cnt = 2'h0;
    always @(posedge i_clk)
    begin
        if (i_press)
            low_cnt <= 2'h2;
        else if (low_cnt != 2'h0)
            low_cnt <= low_cnt - 2'h1;
    end
    assign o_start_pause_n = (low_cnt == 2'h0);
    assign o_stop_reset_in = i_stop;
    assign o_button_mode = 1'b1;
endmodule

// ===== verification/push_button_record_play_control_test.sv
// Self-checking bench for the push-button control block.
`timescale 1ns/1ns
module push_button_record_play_control_test;
    import button_ctrl_pkg::*;
    localparam int PUD = 4;
    localparam int DB = 8;
    localparam logic [15:0] LAST = 16'h0007;
    typedef struct packed {
        logic play;
        logic del;
        logic cue;
        logic [15:0] res;
        logic [1:0] wr;
        logic er;
    } row_s;
    row_s rows [4] = '{'{1'b0, 1'b0, 1'b0, 16'h0004, 2'h2, 1'b0},
                       '{1'b0, 1'b1, 1'b0, 16'h0003, 2'h2, 1'b1},
                       '{1'b1, 1'b0, 1'b0, 16'h0003, 2'h0, 1'b0},
                       '{1'b1, 1'b0, 1'b1, 16'h0004, 2'h0, 1'b0}};
    logic clk, resetn, press, stop, play_sel, cue, del, found, next_msg, loop;
    logic start_n, stop_in, bmode, run, ovf_n, powered, record, mwrite, merase;
    logic [15:0] addr;
    int error_cnt, num_checks, k, wr0, er0;
    int n_wr = 0;
    int n_er = 0;
    ////////////////////////////////////////////////////////////////////////////
    button_pad u_button_pad (.i_clk(clk), .i_press(press), .i_stop(stop),
        .o_start_pause_n(start_n), .o_stop_reset_in(stop_in), .o_button_mode(bmode));
    button_ctrl #(.PUD_COUNT(PUD), .DB_COUNT(DB), .END_ADDR(LAST)) u_button_ctrl (.i_clk(clk),
        .i_resetn(resetn), .i_start_pause_n(start_n), .i_stop_reset_in(stop_in),
        .i_play_sel(play_sel), .i_button_mode(bmode), .i_cue_mode(cue),
        .i_marker_delete_mode(del), .i_loop_mode(loop), .i_marker_found(found),
        .i_next_msg(next_msg), .o_run_marker_out(run), .o_overflow_out_n(ovf_n),
        .o_powered(powered), .o_record(record), .o_marker_write(mwrite),
        .o_marker_erase(merase), .o_address(addr));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (mwrite === 1'b1)
            n_wr <= n_wr + 1;
        if (merase === 1'b1)
            n_er <= n_er + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic push();
        @(posedge clk) press <= 1'b1;
        @(posedge clk) press <= 1'b0;
    endtask
    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge clk) next_msg <= 1'b1;
            @(posedge clk) next_msg <= 1'b0;
        end
    endtask
    task automatic wait_run(input logic val);
        k = 0;
        while (run !== val && k < 40)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 40)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic stop_all();
        @(posedge clk) stop <= 1'b1;
        tick(4);
        check(addr, 16'h0000);
        check(run, 1'b0);
        check(powered, 1'b0);
        @(posedge clk) stop <= 1'b0;
        tick(DB + 4);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {resetn, press, stop, play_sel, cue, del, found, next_msg, loop} = 9'h000;
        {error_cnt, num_checks} = {2{32'h0}};
        tick(12);
        resetn <= 1'b1;
        tick(2);
        check(run, 1'b0);
        check(ovf_n, 1'b1);
        check(addr, 16'h0000);
        foreach (rows[i])
        begin
            @(posedge clk) {play_sel, del, cue} <= {rows[i].play, rows[i].del, rows[i].cue};
            tick(DB + 4);
            wr0 = n_wr;
            er0 = n_er;
            push();
            wait_run(1'b1);
            check(16'(k > PUD), 16'h0001);
            check(record, {15'h0000, ~rows[i].play});
            step(3);
            tick(DB + 4);
            push();
            wait_run(1'b0);
            check(addr, 16'h0003);
            check(powered, 1'b1);
            tick(DB + 8);
            check(powered, 1'b0);
            push();
            wait_run(1'b1);
            check(addr, rows[i].res);
            stop_all();
            check(16'(n_wr - wr0), 16'(rows[i].wr));
            check(16'(n_er - er0), 16'(rows[i].er));
        end
        @(posedge clk) {play_sel, del, cue} <= 3'h4;
        push();
        wait_run(1'b1);
        step(2);
        tick(DB + 4);
        push();
        wait_run(1'b0);
        push();
        tick(20);
        check(run, 1'b0);
        tick(DB + 4);
        push();
        wait_run(1'b1);
        @(posedge clk) found <= 1'b1;
        @(posedge clk) found <= 1'b0;
        wait_run(1'b0);
        check(addr, 16'h0002);
        @(posedge clk) play_sel <= 1'b0;
        tick(DB + 4);
        push();
        wait_run(1'b1);
        check(addr, 16'h0002);
        check(record, 1'b1);
        step(1);
        tick(DB + 4);
        push();
        wait_run(1'b0);
        @(posedge clk) play_sel <= 1'b1;
        tick(DB + 4);
        push();
        wait_run(1'b1);
        check(addr, 16'h0000);
        step(8);
        tick(2);
        check(ovf_n, 1'b0);
        check(run, 1'b0);
        check(addr, LAST);
        tick(DB + 4);
        push();
        wait_run(1'b1);
        check(addr, 16'h0000);
        check(ovf_n, 1'b1);
        check(record, 1'b0);
        @(posedge clk) loop <= 1'b1;
        step(8);
        tick(2);
        check(addr, 16'h0000);
        check(ovf_n, 1'b1);
        check(run, 1'b1);
        stop_all();
        end_of_test();
    end
endmodule
